// [mem_io_decoder.sv]
// memory page, port strobe, start-up overlay and wait-state logic
// How it works
// - system ram only at c800-cbff
// - row a0-4, column a5-9, page a10-15
// - ram write enable follows memory-write status
// - rom read only, ignores memory-write status
// - outside overlay, pages decoded only when a15-12 equal 1100
// - a11-10 pick rom0, rom1, system ram, display ram
// - page hit when any page enable active
// - overlay maps page 0 to rom, hides page c
// - page decode off during input or output cycles
// - ready low mid-sync on a page hit or any i/o cycle, until next phase-2 rise
// - ports only when a15-11 all ones
// - a10-8 pick one of eight strobes
// - input needs data-in; output needs write strobe
// - internal-bus select for input ports f8-fb
// - jumpered interrupt acknowledge disables all decoders
// - output strobes fe, fd, fb, fa, f9, f8 assigned
// - port f8 write latches data bit 4 as rts
// - input strobes ff down to f8 assigned
// - overlay active for first four fetches
`timescale 1ns/1ns
module mem_io_decoder (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] adr,
  input wire logic [7:0] dout,
  input wire logic sinp,
  input wire logic sout,
  input wire logic sinta,
  input wire logic smemr_m1,
  input wire logic mwrite,
  input wire logic pdbin,
  input wire logic pwr_n,
  input wire logic psync,
  input wire logic phi2,
  input wire logic inta_jumper,
  output logic rom0_en_n,
  output logic rom1_en_n,
  output logic sram_en_n,
  output logic vram_en_n,
  output logic sram_we_n,
  output logic [4:0] sram_row,
  output logic [4:0] sram_col,
  output logic mem_hit,
  output logic int_sel,
  output logic prdy,
  output logic overlay_n,
  output logic rts,
  output logic scroll_load_strobe_n,
  output logic parallel_out_strobe_n,
  output logic cassette_tx_strobe_n,
  output logic control_bits_strobe_n,
  output logic serial_tx_strobe_n,
  output logic rts_latch_strobe_n,
  output logic switch_read_strobe_n,
  output logic scroll_status_read_n,
  output logic parallel_in_strobe_n,
  output logic keyboard_read_strobe_n,
  output logic cassette_rx_strobe_n,
  output logic aux_status_read_n,
  output logic serial_rx_strobe_n,
  output logic serial_status_read_n
);
  import decoder_pkg::*;

  // bus pins come from another timing world; two stages each
  localparam int nin = 34;
  logic [nin-1:0] sync1, sync2;
  logic rst1, rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst1 <= 1'b1;
      rst_n <= rst1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {adr, dout, sinp, sout, sinta, smemr_m1, mwrite, pdbin, pwr_n, psync, phi2,
                inta_jumper};
      sync2 <= sync1;
    end
  end
  logic [15:0] a;
  logic [7:0] d;
  logic s_inp, s_out, s_inta, s_m1, s_mw, s_dbin, s_wr_n, s_sync, s_phi2, s_jmp;
  assign {a, d, s_inp, s_out, s_inta, s_m1, s_mw, s_dbin, s_wr_n, s_sync, s_phi2, s_jmp}
    = sync2;

  function automatic logic [7:0] onehot8(input logic [2:0] sel);
    onehot8 = 8'h01 << sel;
  endfunction : onehot8

  typedef enum logic [2:0] {
    rdy_idle = 3'b001,
    rdy_wait = 3'b010,
    rdy_done = 3'b100
  } rdy_state_t;

  // state registers
  rdy_state_t state, next_state;
  logic [2:0] fetch_cnt, next_fetch_cnt;
  logic dbin_q, next_dbin_q;
  logic phi2_q, next_phi2_q;
  logic rts_q, next_rts_q;
  logic [3:0] page_en, next_page_en;
  logic [7:0] in_stb, next_in_stb, out_stb, next_out_stb;
  logic next_we_n, next_hit, next_int_sel, next_prdy, next_overlay_n;
  logic [4:0] next_row, next_col;
  logic [7:0] page_dec;
  // pins get inverted copies held in flops, so no gate sits after a register
  logic [3:0] page_sel_n, next_page_sel_n;
  logic [7:0] in_strobe_n, next_in_strobe_n, out_strobe_n, next_out_strobe_n;

  logic overlay_act, page_ok, io_cyc, inta_block, port_ok;
  always_comb begin
    overlay_act = (fetch_cnt != overlay_fetches);
    inta_block = s_jmp && s_inta;
    io_cyc = s_inp || s_out;
    // overlay hides page c and lets page 0 reach rom0 instead
    page_ok = overlay_act ? (a[15:12] == zero_hi_nibble) && (a[11:10] == page_rom0)
                          : (a[15:12] == page_hi_nibble);
    page_dec = onehot8({1'b0, a[page_sel_lsb +: 2]});
    next_page_en = '0;
    if (page_ok && !io_cyc && !inta_block) begin
      next_page_en = page_dec[3:0];
    end
    next_hit = |next_page_en;
    next_we_n = !(next_page_en[page_sram] && s_mw);
    next_row = a[adr_row_lsb +: adr_row_w];
    next_col = a[adr_col_lsb +: adr_col_w];
    port_ok = (a[15:11] == port_hi_bits) && !inta_block;
    next_in_stb = (port_ok && s_dbin && s_inp) ? onehot8(a[port_sel_lsb +: 3]) : 8'h00;
    next_out_stb = (port_ok && !s_wr_n && s_out) ? onehot8(a[port_sel_lsb +: 3]) : 8'h00;
    next_int_sel = |next_in_stb[port_fb:port_f8];
    next_page_sel_n = ~next_page_en;
    next_in_strobe_n = ~next_in_stb;
    next_out_strobe_n = ~next_out_stb;
    next_rts_q = rts_q;
    if (next_out_stb[port_f8]) begin
      next_rts_q = d[rts_data_bit];
    end
    next_dbin_q = s_dbin;
    next_phi2_q = s_phi2;
    next_fetch_cnt = fetch_cnt;
    // count fetch data-in pulses, saturating at four
    if (overlay_act && s_dbin && !dbin_q && s_m1) begin
      next_fetch_cnt = fetch_cnt + 3'h1;
    end
    next_overlay_n = !(next_fetch_cnt != overlay_fetches);
    next_state = state;
    case (state)
      rdy_idle: begin
        // mid-sync: sync high while phase 2 low
        if (s_sync && !s_phi2 && (next_hit || io_cyc)) begin
          next_state = rdy_wait;
        end
      end
      rdy_wait: begin
        if (s_phi2 && !phi2_q && !s_sync) begin
          next_state = rdy_done;
        end
      end
      rdy_done: begin
        if (!s_sync) begin
          next_state = rdy_idle;
        end
      end
      default: next_state = rdy_idle;
    endcase
    // processor waits while this is low
    next_prdy = (next_state != rdy_wait);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rdy_idle;
      fetch_cnt <= '0;
      dbin_q <= 1'b0;
      phi2_q <= 1'b0;
      rts_q <= rts_reset;
      page_en <= '0;
      in_stb <= '0;
      out_stb <= '0;
      page_sel_n <= '1;
      in_strobe_n <= '1;
      out_strobe_n <= '1;
      sram_we_n <= 1'b1;
      mem_hit <= 1'b0;
      int_sel <= 1'b0;
      prdy <= 1'b1;
      overlay_n <= 1'b0;
      sram_row <= '0;
      sram_col <= '0;
    end else begin
      state <= next_state;
      fetch_cnt <= next_fetch_cnt;
      dbin_q <= next_dbin_q;
      phi2_q <= next_phi2_q;
      rts_q <= next_rts_q;
      page_en <= next_page_en;
      in_stb <= next_in_stb;
      out_stb <= next_out_stb;
      page_sel_n <= next_page_sel_n;
      in_strobe_n <= next_in_strobe_n;
      out_strobe_n <= next_out_strobe_n;
      sram_we_n <= next_we_n;
      mem_hit <= next_hit;
      int_sel <= next_int_sel;
      prdy <= next_prdy;
      overlay_n <= next_overlay_n;
      sram_row <= next_row;
      sram_col <= next_col;
    end
  end

  // all strobes active low; one-hot source keeps at most one low
  assign {vram_en_n, sram_en_n, rom1_en_n, rom0_en_n} = page_sel_n;
  assign rts = rts_q;
  assign switch_read_strobe_n = in_strobe_n[port_ff];
  assign scroll_status_read_n = in_strobe_n[port_fe];
  assign parallel_in_strobe_n = in_strobe_n[port_fd];
  assign keyboard_read_strobe_n = in_strobe_n[port_fc];
  assign cassette_rx_strobe_n = in_strobe_n[port_fb];
  assign aux_status_read_n = in_strobe_n[port_fa];
  assign serial_rx_strobe_n = in_strobe_n[port_f9];
  assign serial_status_read_n = in_strobe_n[port_f8];
  assign scroll_load_strobe_n = out_strobe_n[port_fe];
  assign parallel_out_strobe_n = out_strobe_n[port_fd];
  assign cassette_tx_strobe_n = out_strobe_n[port_fb];
  assign control_bits_strobe_n = out_strobe_n[port_fa];
  assign serial_tx_strobe_n = out_strobe_n[port_f9];
  assign rts_latch_strobe_n = out_strobe_n[port_f8];

  AST_ONE_PAGE: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0(page_en)) else $error("more than one page select");
  AST_ONE_PORT: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0({in_stb, out_stb})) else $error("more than one port strobe");
  AST_HIT: assert property (@(posedge clk) disable iff (!rst_n)
    mem_hit == (page_en != 4'h0)) else $error("page hit mismatch");
  AST_IO_NOPAGE: assert property (@(posedge clk) disable iff (!rst_n)
    (s_inp || s_out) |=> page_en == 4'h0) else $error("page during io cycle");
  AST_INTA: assert property (@(posedge clk) disable iff (!rst_n)
    (s_jmp && s_inta) |=> (page_en == 4'h0) && (in_stb == 8'h00) && (out_stb == 8'h00))
    else $error("decode during interrupt acknowledge");
  AST_WE: assert property (@(posedge clk) disable iff (!rst_n)
    !sram_we_n |-> page_en[page_sram]) else $error("write enable outside ram");
  AST_INTSEL: assert property (@(posedge clk) disable iff (!rst_n)
    int_sel == (in_stb[3:0] != 4'h0)) else $error("internal select mismatch");
  AST_OVERLAY: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(overlay_n) |-> fetch_cnt == overlay_fetches) else $error("overlay released early");
  AST_RTS: assert property (@(posedge clk) disable iff (!rst_n)
    out_stb[port_f8] |-> rts == $past(d[rts_data_bit])) else $error("rts not latched");
  // decode checks look one cycle back at the synchronised inputs
  AST_PAGE_HI: assert property (@(posedge clk) disable iff (!rst_n)
    (page_en != 4'h0) |-> ($past(a[15:12]) == page_hi_nibble) || ($past(a[15:10]) == 6'h00))
    else $error("page select outside page c");
  AST_PAGE_SEL: assert property (@(posedge clk) disable iff (!rst_n)
    (page_en != 4'h0) |-> (page_en == (4'h1 << $past(a[11:10]))))
    else $error("wrong page select");
  AST_HIDE_C: assert property (@(posedge clk) disable iff (!rst_n)
    ((page_en != 4'h0) && $past(overlay_act))
      |-> (page_en == 4'h1) && ($past(a[15:10]) == 6'h00))
    else $error("page c decoded during overlay");
  AST_PORT_HI: assert property (@(posedge clk) disable iff (!rst_n)
    ({in_stb, out_stb} != 16'h0000) |-> ($past(a[15:11]) == port_hi_bits))
    else $error("port strobe outside f8-ff");
  AST_PORT_SEL: assert property (@(posedge clk) disable iff (!rst_n)
    ({in_stb, out_stb} != 16'h0000) |-> ((in_stb | out_stb) == (8'h01 << $past(a[10:8]))))
    else $error("wrong port strobe");
  AST_IN_QUAL: assert property (@(posedge clk) disable iff (!rst_n)
    (in_stb != 8'h00) |-> $past(s_dbin && s_inp))
    else $error("input strobe without data-in");
  AST_OUT_QUAL: assert property (@(posedge clk) disable iff (!rst_n)
    (out_stb != 8'h00) |-> $past(!s_wr_n && s_out))
    else $error("output strobe without write");
  AST_ROW_COL: assert property (@(posedge clk) disable iff (!rst_n)
    {sram_col, sram_row} == $past(a[9:0])) else $error("row or column address wrong");
  AST_WE_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    page_en[page_sram] |-> (sram_we_n == !$past(s_mw)))
    else $error("write enable not following status");
  AST_WAIT_START: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(prdy) |-> $past(s_sync && !s_phi2 && (next_hit || io_cyc)))
    else $error("wait state without mid-sync decode");
  AST_WAIT_END: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(prdy) |-> $past(s_phi2 && !phi2_q && !s_sync))
    else $error("wait state ended off the phase-2 rise");
  AST_FETCH_CAP: assert property (@(posedge clk) disable iff (!rst_n)
    fetch_cnt <= overlay_fetches) else $error("fetch count past four");
  COV_OUT: cover property (@(posedge clk) disable iff (!rst_n) out_stb[port_f8]);
  COV_WAIT: cover property (@(posedge clk) disable iff (!rst_n) $fell(prdy));
  COV_RAM_WR: cover property (@(posedge clk) disable iff (!rst_n) !sram_we_n);
  COV_IN: cover property (@(posedge clk) disable iff (!rst_n) in_stb[port_fc]);
  COV_OVL: cover property (@(posedge clk) disable iff (!rst_n) $rose(overlay_n));
endmodule : mem_io_decoder

// [decoder_pkg.sv]
// constants for the memory and port address decoder
package decoder_pkg;
  localparam logic [3:0] page_hi_nibble = 4'hc;
  localparam logic [3:0] zero_hi_nibble = 4'h0;
  localparam logic [4:0] port_hi_bits = 5'h1f;
  localparam int adr_row_lsb = 0;
  localparam int adr_row_w = 5;
  localparam int adr_col_lsb = 5;
  localparam int adr_col_w = 5;
  localparam int page_sel_lsb = 10;
  localparam int port_sel_lsb = 8;
  localparam logic [1:0] page_rom0 = 2'h0;
  localparam logic [1:0] page_rom1 = 2'h1;
  localparam logic [1:0] page_sram = 2'h2;
  localparam logic [1:0] page_vram = 2'h3;
  localparam logic [2:0] port_f8 = 3'h0;
  localparam logic [2:0] port_f9 = 3'h1;
  localparam logic [2:0] port_fa = 3'h2;
  localparam logic [2:0] port_fb = 3'h3;
  localparam logic [2:0] port_fc = 3'h4;
  localparam logic [2:0] port_fd = 3'h5;
  localparam logic [2:0] port_fe = 3'h6;
  localparam logic [2:0] port_ff = 3'h7;
  localparam int rts_data_bit = 4;
  localparam logic [2:0] overlay_fetches = 3'h4;
  localparam logic rts_reset = 1'b0;
endpackage : decoder_pkg

// [cpu_bus_model.sv]
// processor-side model: phase-2 clock, sync pulses and ready sampling
`timescale 1ns/1ns
module cpu_bus_model (
  input wire logic clk,
  input wire logic go,
  input wire logic prdy,
  output logic psync,
  output logic phi2,
  output logic waited
);
  logic [3:0] ph = 4'h0;
  initial begin
    phi2 = 1'b0;
    psync = 1'b0;
    waited = 1'b0;
  end
  // slow phase-2 so the decoder's three-edge input latency fits inside each phase
  always @(posedge clk) begin
    ph <= ph + 4'h1;
    phi2 <= ph[3];
    if (ph == 4'h8 && psync) begin
      psync <= 1'b0;
      waited <= !prdy;
    end else if (ph == 4'h8 && go) begin
      psync <= 1'b1;
    end
  end
endmodule : cpu_bus_model

// [test_memory_io_address_decoder.sv]
// random and corner-case bench for the memory and port address decoder
`timescale 1ns/1ns
module test_memory_io_address_decoder;
  import decoder_pkg::*;
  logic clk, arst_n, sinp, sout, sinta, smemr_m1, mwrite, pdbin, pwr_n, inta_jumper, go, ov, er;
  logic psync, phi2, waited, rom0_en_n, rom1_en_n, sram_en_n, vram_en_n, sram_we_n, mem_hit;
  logic int_sel, prdy, overlay_n, rts, scroll_load_strobe_n, parallel_out_strobe_n;
  logic cassette_tx_strobe_n, control_bits_strobe_n, serial_tx_strobe_n, rts_latch_strobe_n;
  logic switch_read_strobe_n, scroll_status_read_n, parallel_in_strobe_n, keyboard_read_strobe_n;
  logic cassette_rx_strobe_n, aux_status_read_n, serial_rx_strobe_n, serial_status_read_n;
  logic [15:0] adr, a;
  logic [7:0] dout, ins, outs;
  logic [4:0] sram_row, sram_col;
  logic [3:0] pg;
  logic [31:0] r;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  assign pg = {vram_en_n, sram_en_n, rom1_en_n, rom0_en_n};
  assign ins = {switch_read_strobe_n, scroll_status_read_n, parallel_in_strobe_n,
    keyboard_read_strobe_n, cassette_rx_strobe_n, aux_status_read_n, serial_rx_strobe_n,
    serial_status_read_n};
  assign outs = {1'b1, scroll_load_strobe_n, parallel_out_strobe_n, 1'b1, cassette_tx_strobe_n,
    control_bits_strobe_n, serial_tx_strobe_n, rts_latch_strobe_n};
  mem_io_decoder uut (.*);
  cpu_bus_model cpu (.*);
  task automatic close_out();
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // status s: sinp, sout, sinta, mwrite, pdbin, pwr_n, jumper
  function automatic logic [3:0] exp_pg(logic [15:0] a, logic [6:0] s);
    exp_pg = 4'hf;
    if (!(s[6] | s[5] | (s[4] & s[0])) && a[15:12] == (ov ? page_hi_nibble : zero_hi_nibble))
      if (ov || a[11:10] == page_rom0) exp_pg[a[11:10]] = 1'b0;
  endfunction : exp_pg
  function automatic logic [7:0] exp_port(logic [15:0] a, logic [6:0] s, logic dir);
    exp_port = 8'hff;
    if (a[15:11] == port_hi_bits && !(s[4] & s[0]) && (dir ? s[6] & s[2] : s[5] & !s[1]))
      exp_port[a[10:8]] = 1'b0;
  endfunction : exp_port
  task automatic put(input logic [15:0] a, input logic [7:0] d, input logic [6:0] s);
    logic [3:0] pe;
    logic [7:0] ie, oe;
    adr <= a;
    dout <= d;
    {sinp, sout, sinta, mwrite, pdbin, pwr_n, inta_jumper} <= s;
    repeat (4) @(posedge clk);
    pe = exp_pg(a, s);
    ie = exp_port(a, s, 1'b1);
    oe = exp_port(a, s, 1'b0) | 8'h90;
    if (!oe[0]) er = d[4];
    chk("pages", pe, pg);
    chk("mem_hit", pe != 4'hf, mem_hit);
    chk("in_strobes", ie, ins);
    chk("out_strobes", oe, outs);
    chk("int_sel", ie[3:0] != 4'hf, int_sel);
    chk("row_col", a[9:0], {sram_col, sram_row});
    if (!pe[2]) chk("sram_we_n", !s[3], sram_we_n);
    chk("rts", er, rts);
  endtask : put
  task automatic bus(input logic [15:0] a, input logic [6:0] s, input logic w);
    put(a, 8'h00, s);
    go <= 1'b1;
    do @(posedge clk); while (!psync);
    go <= 1'b0;
    do @(posedge clk); while (psync);
    chk("waited", w, waited);
    repeat (6) @(posedge clk);
    chk("prdy", 1'b1, prdy);
  endtask : bus
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, far above the roughly 1500 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    {arst_n, go, ov, er, adr, dout} = '0;
    {sinp, sout, sinta, mwrite, pdbin, pwr_n, inta_jumper, smemr_m1} = 8'h04;
    void'($urandom(90019));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    put(16'hc000, 8'h00, 7'h02);
    put(16'h0200, 8'h00, 7'h0a);
    for (int i = 0; i < 4; i++) begin
      chk("overlay_n", 1'b0, overlay_n);
      smemr_m1 <= 1'b1;
      @(posedge clk);
      pdbin <= 1'b1;
      repeat (4) @(posedge clk);
      {pdbin, smemr_m1} <= 2'b00;
      repeat (4) @(posedge clk);
    end
    chk("overlay_n", 1'b1, overlay_n);
    ov = 1'b1;
    for (int i = 0; i < 4; i++) put({4'hc, i[1:0], 10'h2a5}, 8'h00, {3'h0, i[0], 3'h2});
    for (int i = 0; i < 8; i++) begin
      put({5'h1f, i[2:0], 8'h00}, 8'h00, 7'h46);
      put({5'h1f, i[2:0], 8'h00}, 8'h10, 7'h20);
    end
    put(16'hf800, 8'hef, 7'h20);
    put(16'hc800, 8'h00, 7'h1b);
    put(16'hf900, 8'h00, 7'h57);
    put(16'hc400, 8'h00, 7'h42);
    bus(16'hc800, 7'h0a, 1'b1);
    bus(16'hfa00, 7'h42, 1'b1);
    bus(16'h1234, 7'h02, 1'b0);
    repeat (300) begin
      r = $urandom;
      a = r[31:16];
      if (r[0]) a[15:11] = port_hi_bits;
      else if (r[1]) a[15:12] = page_hi_nibble;
      // a processor never shows input and output status together
      put(a, r[15:8], r[8:2] & {1'b1, !r[8], 5'h1f});
    end
    close_out();
  end
endmodule : test_memory_io_address_decoder
